/* cksup_regs.vh */
// Register map, field positions, reset values and timing counts of the
// clock switch / reset supervisor.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef CKSUP_REGS_VH
`define CKSUP_REGS_VH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define CKSUP_ADDR_OSC_CTRL 2'h0
`define CKSUP_ADDR_RST_CTRL 2'h1
`define CKSUP_ADDR_CMD 2'h2

// ----------------------------------------------------------------
// Oscillator control fields
// ----------------------------------------------------------------
`define CKSUP_OSC_SWEN_BIT 0
`define CKSUP_OSC_CF_BIT 3
`define CKSUP_OSC_LOCK_BIT 5
`define CKSUP_OSC_NEW_OSC_GROUP_LSB 8
`define CKSUP_OSC_CURRENT_OSC_GROUP_LSB 12

// ----------------------------------------------------------------
// Reset control fields
// ----------------------------------------------------------------
`define CKSUP_RST_POR_BIT 0
`define CKSUP_RST_BOR_BIT 1
`define CKSUP_RST_SLEEP_BIT 3
`define CKSUP_RST_WATCHDOG_TIMEOUT_FLAG_BIT 4
`define CKSUP_RST_SOFTWARE_WATCHDOG_ENABLE_BIT 5
`define CKSUP_RST_SWR_BIT 6
`define CKSUP_RST_EXTR_BIT 7
`define CKSUP_RST_LOW_VOLTAGE_THRESHOLD_SELECT_LSB 8
`define CKSUP_RST_LOW_VOLTAGE_DETECT_ENABLE_BIT 12
`define CKSUP_RST_REFERENCE_STABLE_FLAG_BIT 13
`define CKSUP_RST_ILLEGAL_OP_RESET_BIT 14
`define CKSUP_RST_TRAP_LOCKUP_RESET_BIT 15

// ----------------------------------------------------------------
// Command register bits (write only)
// ----------------------------------------------------------------
`define CKSUP_CMD_WDT_CLEAR_BIT 0
`define CKSUP_CMD_SW_RESET_BIT 1
`define CKSUP_CMD_SLEEP_BIT 2

// ----------------------------------------------------------------
// Group codes, unlock keys, reset values
// ----------------------------------------------------------------
`define CKSUP_GRP_FRC 2'h1
`define CKSUP_KEY_LO1 8'h46
`define CKSUP_KEY_LO2 8'h57
`define CKSUP_KEY_HI1 8'h78
`define CKSUP_KEY_HI2 8'h9A
`define CKSUP_RST_CTRL_RESET 16'h0000

// ----------------------------------------------------------------
// Timing (time in its unit, count derived from the 50 ns period)
// ----------------------------------------------------------------
`define CKSUP_CLK_NS 50
`define CKSUP_BIAS_SETTLE_NS 10000
`define CKSUP_BIAS_SETTLE_CYC (`CKSUP_BIAS_SETTLE_NS / `CKSUP_CLK_NS)
`define CKSUP_POWER_UP_TIMER_4MS_NS 4000000
`define CKSUP_POWER_UP_TIMER_16MS_NS 16000000
`define CKSUP_POWER_UP_TIMER_64MS_NS 64000000
`define CKSUP_POWER_UP_TIMER_4MS_CYC (`CKSUP_POWER_UP_TIMER_4MS_NS / `CKSUP_CLK_NS)
`define CKSUP_POWER_UP_TIMER_16MS_CYC (`CKSUP_POWER_UP_TIMER_16MS_NS / `CKSUP_CLK_NS)
`define CKSUP_POWER_UP_TIMER_64MS_CYC (`CKSUP_POWER_UP_TIMER_64MS_NS / `CKSUP_CLK_NS)
`define CKSUP_FILTER_CYC 4

`endif

/* cksup_pin_filter.v */
// Noise filter for the external reset input.
// Input is synchronous to clk; output changes only after a stable run.
`timescale 1ns/1ps
module cksup_pin_filter #(
  parameter LEN = 4
) (
  input wire clk,
  input wire rst_b,
  input wire pin_in_b,
  output reg pin_out_b
);
  reg [7:0] run_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 8'h00;
      pin_out_b <= 1'b1;
    end else if (pin_in_b == pin_out_b) begin
      run_q <= 8'h00;
    end else if (run_q == LEN[7:0] - 8'h01) begin
      // Short pulses never reach this count
      run_q <= 8'h00;
      pin_out_b <= pin_in_b;
    end else begin
      run_q <= run_q + 8'h01;
    end
  end
endmodule // cksup_pin_filter

/* cksup_top.v */
// Clock switch, fail-safe monitor, reset cause, power-up delay, watchdog.
// Registers on a plain port, read data one cycle after the read strobe.
`timescale 1ns/1ps
`include "cksup_regs.vh"

module cksup_top #(
  parameter WDT_W = 8,
  parameter POWER_UP_TIMER_4MS = `CKSUP_POWER_UP_TIMER_4MS_CYC,
  parameter POWER_UP_TIMER_16MS = `CKSUP_POWER_UP_TIMER_16MS_CYC,
  parameter POWER_UP_TIMER_64MS = `CKSUP_POWER_UP_TIMER_64MS_CYC
) (
  input wire clk,
  input wire rst_b,
  input wire [1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [1:0] reg_byte_en,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire por_event,
  input wire bor_event,
  input wire trap_lockup,
  input wire illegal_op,
  input wire external_reset_pin_b,
  input wire [1:0] osc_group_config,
  input wire [3:0] primary_osc_select,
  input wire [1:0] clock_monitor_config,
  input wire [1:0] power_up_delay_sel,
  input wire watchdog_config_enable,
  input wire clock_missing,
  input wire osc_started,
  input wire pll_locked,
  input wire reference_ready,
  input wire low_power_internal_rc_tick,
  output reg internal_system_reset_b,
  output reg [1:0] osc_group_sel,
  output reg [3:0] primary_sel,
  output reg clock_fail_trap,
  output reg wake_up
);
  localparam [3:0] ST_BIAS = 4'b0001;
  localparam [3:0] ST_POWER_UP_TIMER = 4'b0010;
  localparam [3:0] ST_RUN = 4'b0100;
  localparam [3:0] ST_SLEEP = 4'b1000;

  reg [3:0] state_q;
  reg [31:0] cnt_q;
  reg [1:0] current_osc_group_q;
  reg [1:0] new_osc_group_q;
  reg swen_q;
  reg cf_q;
  reg [15:0] reset_control_q;
  reg [1:0] lo_unlk_q;
  reg [1:0] hi_unlk_q;
  reg [WDT_W-1:0] wdt_q;
  reg ext_b_q;
  reg pwr_event_q;
  wire ext_filt_b;
  wire switch_ok;
  wire wdt_on;
  wire wdt_ovf;
  wire osc_wr;
  wire cmd_wr;
  wire fail_now;
  wire fail_rise;
  reg fail_q;
  reg [31:0] power_up_timer_len;

  function [7:0] byte_of;
    input [15:0] d;
    input hi;
    begin
      byte_of = hi ? d[15:8] : d[7:0];
    end
  endfunction

  cksup_pin_filter #(
    .LEN(`CKSUP_FILTER_CYC)
  ) u_filter (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in_b(external_reset_pin_b),
    .pin_out_b(ext_filt_b)
  );

  // Upper config bit kills switching and monitor
  assign switch_ok = ~clock_monitor_config[1];
  assign wdt_on = watchdog_config_enable |
    reset_control_q[`CKSUP_RST_SOFTWARE_WATCHDOG_ENABLE_BIT];
  assign wdt_ovf = wdt_on & low_power_internal_rc_tick & (&wdt_q);
  assign osc_wr = reg_wr & (reg_addr == `CKSUP_ADDR_OSC_CTRL);
  assign cmd_wr = reg_wr & (reg_addr == `CKSUP_ADDR_CMD);

  always @* begin
    case (power_up_delay_sel)
      2'h1: power_up_timer_len = POWER_UP_TIMER_4MS;
      2'h2: power_up_timer_len = POWER_UP_TIMER_16MS;
      2'h3: power_up_timer_len = POWER_UP_TIMER_64MS;
      default: power_up_timer_len = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_BIAS;
      cnt_q <= 32'h0000_0000;
      internal_system_reset_b <= 1'b0;
      wake_up <= 1'b0;
      ext_b_q <= 1'b1;
      pwr_event_q <= 1'b1;
    end else begin
      ext_b_q <= ext_filt_b;
      wake_up <= 1'b0;
      pwr_event_q <= por_event | bor_event;
      if (por_event | bor_event | ~ext_filt_b | trap_lockup |
          illegal_op | (cmd_wr & reg_wdata[`CKSUP_CMD_SW_RESET_BIT]) |
          (wdt_ovf & (state_q != ST_SLEEP))) begin
        // Overflow outside sleep resets the device
        state_q <= ST_BIAS;
        cnt_q <= 32'h0000_0000;
        internal_system_reset_b <= 1'b0;
      end else begin
        case (state_q)
          ST_BIAS: begin
            cnt_q <= cnt_q + 32'h0000_0001;
            if (cnt_q >= `CKSUP_BIAS_SETTLE_CYC - 1) begin
              state_q <= ST_POWER_UP_TIMER;
              cnt_q <= 32'h0000_0000;
            end
          end
          ST_POWER_UP_TIMER: begin
            cnt_q <= cnt_q + 32'h0000_0001;
            if (cnt_q >= power_up_timer_len) begin
              state_q <= ST_RUN;
              internal_system_reset_b <= 1'b1;
            end
          end
          ST_RUN: begin
            if (cmd_wr & reg_wdata[`CKSUP_CMD_SLEEP_BIT])
              state_q <= ST_SLEEP;
          end
          ST_SLEEP: begin
            // Timeout in sleep wakes instead of reset
            if (wdt_ovf) begin
              state_q <= ST_RUN;
              wake_up <= 1'b1;
            end
          end
          default: state_q <= ST_BIAS;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Failure detection
  // ----------------------------------------------------------------
  // Slow start: oscillator still absent once the delays ran out
  // One trap per failure: a held fault must not retrigger every cycle,
  // while a later fault after recovery still gets its own trap
  assign fail_now = switch_ok & (clock_missing |
    ((state_q == ST_RUN) & ~osc_started));
  assign fail_rise = fail_now & ~fail_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fail_q <= 1'b0;
    end else begin
      fail_q <= fail_now;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator control and unlock
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      current_osc_group_q <= 2'h0;
      new_osc_group_q <= 2'h0;
      swen_q <= 1'b0;
      cf_q <= 1'b0;
      lo_unlk_q <= 2'h0;
      hi_unlk_q <= 2'h0;
      clock_fail_trap <= 1'b0;
      osc_group_sel <= 2'h0;
      primary_sel <= 4'h0;
    end else begin
      clock_fail_trap <= 1'b0;
      // Any other write ends a partial or open unlock
      lo_unlk_q <= 2'h0;
      hi_unlk_q <= 2'h0;
      if (osc_wr & reg_byte_en[0]) begin
        // Low byte key pair, then one open write
        if (lo_unlk_q == 2'h2) begin
          new_osc_group_q <= new_osc_group_q;
          swen_q <= reg_wdata[`CKSUP_OSC_SWEN_BIT];
        end else if (byte_of(reg_wdata, 1'b0) == `CKSUP_KEY_LO1)
          lo_unlk_q <= 2'h1;
        else if (lo_unlk_q == 2'h1 &&
                 byte_of(reg_wdata, 1'b0) == `CKSUP_KEY_LO2)
          lo_unlk_q <= 2'h2;
      end
      if (osc_wr & reg_byte_en[1]) begin
        // High byte key pair, then one open write
        if (hi_unlk_q == 2'h2)
          new_osc_group_q <= reg_wdata[`CKSUP_OSC_NEW_OSC_GROUP_LSB+1:`CKSUP_OSC_NEW_OSC_GROUP_LSB];
        else if (byte_of(reg_wdata, 1'b1) == `CKSUP_KEY_HI1)
          hi_unlk_q <= 2'h1;
        else if (hi_unlk_q == 2'h1 &&
                 byte_of(reg_wdata, 1'b1) == `CKSUP_KEY_HI2)
          hi_unlk_q <= 2'h2;
      end
      if (pwr_event_q) begin
        current_osc_group_q <= osc_group_config;
        new_osc_group_q <= osc_group_config;
        swen_q <= 1'b0;
        cf_q <= 1'b0;
      end else if (fail_rise) begin
        // Fall back to FAST_INTERNAL_RC, flag, drop enable
        current_osc_group_q <= `CKSUP_GRP_FRC;
        cf_q <= 1'b1;
        swen_q <= 1'b0;
        clock_fail_trap <= 1'b1;
      end else if (switch_ok & swen_q & osc_started) begin
        // Switch completes once the oscillator has started and clears the enable
        current_osc_group_q <= new_osc_group_q;
        swen_q <= 1'b0;
      end
      // Configuration drives selection when switching off
      osc_group_sel <= switch_ok ? current_osc_group_q : osc_group_config;
      primary_sel <= primary_osc_select;
    end
  end

  // ----------------------------------------------------------------
  // Reset cause, watchdog and low-voltage control
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_control_q <= `CKSUP_RST_CTRL_RESET;
      wdt_q <= {WDT_W{1'b0}};
    end else begin
      // Counts on the RC tick only
      if (!wdt_on || (cmd_wr & reg_wdata[`CKSUP_CMD_WDT_CLEAR_BIT]) ||
          state_q == ST_BIAS)
        wdt_q <= {WDT_W{1'b0}};
      else if (low_power_internal_rc_tick)
        wdt_q <= wdt_q + {{(WDT_W-1){1'b0}}, 1'b1};
      if (reg_wr && reg_addr == `CKSUP_ADDR_RST_CTRL) begin
        if (reg_byte_en[0])
          reset_control_q[7:0] <= reg_wdata[7:0];
        if (reg_byte_en[1])
          reset_control_q[15:14] <= reg_wdata[15:14];
        if (reg_byte_en[1])
          reset_control_q[12:8] <= reg_wdata[12:8];
      end
      reset_control_q[`CKSUP_RST_REFERENCE_STABLE_FLAG_BIT] <= reference_ready;
      // Causes set after any software write
      if (por_event)
        reset_control_q[`CKSUP_RST_POR_BIT] <= 1'b1;
      if (bor_event)
        reset_control_q[`CKSUP_RST_BOR_BIT] <= 1'b1;
      if (~ext_filt_b & ext_b_q) begin
        reset_control_q[`CKSUP_RST_EXTR_BIT] <= 1'b1;
        reset_control_q[`CKSUP_RST_SLEEP_BIT] <= (state_q == ST_SLEEP);
      end
      if (cmd_wr & reg_wdata[`CKSUP_CMD_SW_RESET_BIT])
        reset_control_q[`CKSUP_RST_SWR_BIT] <= 1'b1;
      if (trap_lockup)
        reset_control_q[`CKSUP_RST_TRAP_LOCKUP_RESET_BIT] <= 1'b1;
      if (illegal_op)
        reset_control_q[`CKSUP_RST_ILLEGAL_OP_RESET_BIT] <= 1'b1;
      if (cmd_wr & reg_wdata[`CKSUP_CMD_SLEEP_BIT])
        reset_control_q[`CKSUP_RST_SLEEP_BIT] <= 1'b1;
      if (wdt_ovf) begin
        // Wake clears timeout flag; reset sets it
        reset_control_q[`CKSUP_RST_WATCHDOG_TIMEOUT_FLAG_BIT] <= (state_q != ST_SLEEP);
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        // Current group, lock and fail flag
        `CKSUP_ADDR_OSC_CTRL: reg_rdata <= {2'h0, current_osc_group_q, 2'h0, new_osc_group_q,
          2'h0, pll_locked, 1'b0, cf_q, 2'h0, swen_q};
        `CKSUP_ADDR_RST_CTRL: reg_rdata <= reset_control_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // cksup_top

/* cksup_props.sv */
// Port-level timing checks for the clock switch / reset supervisor.
// Bound into cksup_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
`include "cksup_regs.vh"
module cksup_props (
  input wire clk,
  input wire rst_b,
  input wire [1:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [1:0] osc_group_config,
  input wire [1:0] clock_monitor_config,
  input wire internal_system_reset_b,
  input wire [1:0] osc_group_sel,
  input wire clock_fail_trap,
  input wire wake_up
);
  localparam int BIAS = `CKSUP_BIAS_SETTLE_CYC;
  logic [8:0] up_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Saturates so a long run cannot wrap back into the bias window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) up_q <= 9'h000;
    else if (up_q != 9'h1FF) up_q <= up_q + 9'h001;
  end
  a_bias_hold: assert property (
    up_q < BIAS |-> !internal_system_reset_b)
    else $error("system reset released inside bias delay");
  a_trap_pulse: assert property (
    clock_fail_trap |=> !clock_fail_trap)
    else $error("clock fail trap longer than one cycle");
  a_trap_to_frc: assert property (
    $rose(clock_fail_trap) |-> ##[0:2] osc_group_sel == `CKSUP_GRP_FRC)
    else $error("clock fail did not select fast rc group");
  a_monitor_off: assert property (
    clock_monitor_config[1] && $past(clock_monitor_config[1])
    |-> !clock_fail_trap)
    else $error("trap raised with monitor disabled");
  a_direct_select: assert property (
    clock_monitor_config[1] && $stable(clock_monitor_config) &&
    $stable(osc_group_config) && internal_system_reset_b &&
    $past(internal_system_reset_b) |-> osc_group_sel == osc_group_config)
    else $error("selection not driven by configuration");
  a_wake_pulse: assert property (
    wake_up |=> !wake_up)
    else $error("wake pulse longer than one cycle");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr[1] |=> reg_rdata == 16'h0000)
    else $error("command or unmapped read not zero");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule // cksup_props

bind cksup_top cksup_props i_props (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .osc_group_config(osc_group_config),
  .clock_monitor_config(clock_monitor_config),
  .internal_system_reset_b(internal_system_reset_b),
  .osc_group_sel(osc_group_sel), .clock_fail_trap(clock_fail_trap),
  .wake_up(wake_up)
);

/* cksup_tb_top.sv */
// Self-checking bench for the supervisor top at 20 MHz.
// Drives every port itself; short power-up counts for run time.
`timescale 1ns/1ps
`include "cksup_regs.vh"
module cksup_tb_top;
  localparam logic [1:0] OSC = `CKSUP_ADDR_OSC_CTRL;
  localparam logic [1:0] RST = `CKSUP_ADDR_RST_CTRL;
  localparam logic [1:0] CMD = `CKSUP_ADDR_CMD;
  logic clk, rst_b, reg_wr, reg_rd, por_event, bor_event, trap_lockup;
  logic illegal_op, pin_b, wdt_cfg, clock_missing, osc_started, pll_locked;
  logic ref_rdy, low_power_internal_rc_tick, tick_en, isr_b, trap, wake;
  logic [1:0] reg_addr, reg_byte_en, grp_cfg, mon_cfg, pud_sel, grp_sel;
  logic [3:0] prim_cfg, prim_sel;
  logic [15:0] reg_wdata, reg_rdata, d;
  int n_fail, num_checks, cyc, n;
  int cb[6] = '{7, 6, 15, 14, 0, 1};

  cksup_top #(.WDT_W(8), .POWER_UP_TIMER_4MS(10), .POWER_UP_TIMER_16MS(20), .POWER_UP_TIMER_64MS(30))
  i_dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_byte_en(reg_byte_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .por_event(por_event), .bor_event(bor_event),
    .trap_lockup(trap_lockup), .illegal_op(illegal_op),
    .external_reset_pin_b(pin_b), .osc_group_config(grp_cfg),
    .primary_osc_select(prim_cfg), .clock_monitor_config(mon_cfg),
    .power_up_delay_sel(pud_sel), .watchdog_config_enable(wdt_cfg),
    .clock_missing(clock_missing), .osc_started(osc_started),
    .pll_locked(pll_locked), .reference_ready(ref_rdy),
    .low_power_internal_rc_tick(low_power_internal_rc_tick), .internal_system_reset_b(isr_b),
    .osc_group_sel(grp_sel), .primary_sel(prim_sel),
    .clock_fail_trap(trap), .wake_up(wake)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watchdog rc tick every fourth cycle; the cycle ceiling cuts a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    low_power_internal_rc_tick <= tick_en && cyc[1:0] == 2'h0;
    if (cyc == 40000) begin
      n_fail++;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Leaves the strobe up so key writes can follow back to back
  task wr(input logic [1:0] a, input logic [1:0] be, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_byte_en <= be;
    reg_wdata <= v;
  endtask
  task idle;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [1:0] a);
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function logic sig(input int k);
    case (k)
      0: sig = trap;
      1: sig = wake;
      2: sig = isr_b;
      default: sig = !isr_b;
    endcase
  endfunction
  task wait_on(input int k);
    n = 0;
    while (sig(k) !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task drv(input int k);
    pin_b <= (k != 0);
    trap_lockup <= (k == 2);
    illegal_op <= (k == 3);
    por_event <= (k == 4);
    bor_event <= (k == 5);
  endtask
  task end_sim;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_powerup;
    wait_on(2);
    chk(16'(n >= 205 && n <= 215), 16'h0001);
    rd(OSC);
    chk(d & 16'h3300, 16'h2200);
    $display("test powerup done");
  endtask
  task t_unlock;
    wr(OSC, 2'b10, {`CKSUP_KEY_HI1, 8'h00});
    wr(OSC, 2'b10, {`CKSUP_KEY_HI2, 8'h00});
    wr(OSC, 2'b10, 16'h0300);
    wr(OSC, 2'b10, 16'h0100);
    wr(OSC, 2'b10, {`CKSUP_KEY_HI1, 8'h00});
    wr(OSC, 2'b01, 16'h0000);
    wr(OSC, 2'b10, {`CKSUP_KEY_HI2, 8'h00});
    wr(OSC, 2'b10, 16'h0100);
    rd(OSC);
    chk(d & 16'h0300, 16'h0300);
    // Target group is taken to run well above the monitor floor
    wr(OSC, 2'b01, {8'h00, `CKSUP_KEY_LO1});
    wr(OSC, 2'b01, {8'h00, `CKSUP_KEY_LO2});
    wr(OSC, 2'b01, 16'h0001);
    idle;
    repeat (4) @(posedge clk);
    rd(OSC);
    chk(d & 16'h3301, 16'h3300);
    chk({14'h0, grp_sel}, 16'h0003);
    $display("test unlock done");
  endtask
  task t_fail;
    @(posedge clk);
    clock_missing <= 1'b1;
    wait_on(0);
    chk({15'h0, trap}, 16'h0001);
    clock_missing <= 1'b0;
    rd(OSC);
    chk(d & 16'h3029, 16'h1028);
    @(posedge clk);
    mon_cfg <= 2'b10;
    grp_cfg <= 2'h0;
    prim_cfg <= 4'h5;
    repeat (3) @(posedge clk);
    clock_missing <= 1'b1;
    repeat (5) @(posedge clk);
    clock_missing <= 1'b0;
    #1 chk({14'h0, grp_sel}, 16'h0000);
    wr(RST, 2'b10, 16'h1A00);
    rd(RST);
    chk(d & 16'h3F00, 16'h3A00);
    $display("test fail and fields done");
  endtask
  task t_causes;
    @(posedge clk);
    pin_b <= 1'b0;
    repeat (2) @(posedge clk);
    pin_b <= 1'b1;
    n = 0;
    repeat (10) @(posedge clk) n += int'(isr_b !== 1'b1);
    chk(16'(n), 16'h0000);
    for (int k = 0; k < 6; k++) begin
      if (k == 1) wr(CMD, 2'b11, 16'h0002);
      @(posedge clk);
      reg_wr <= 1'b0;
      drv(k);
      repeat (8) @(posedge clk);
      drv(-1);
      #1 chk({15'h0, isr_b}, 16'h0000);
      wait_on(2);
      rd(RST);
      chk({15'h0, d[cb[k]]}, 16'h0001);
      rd(OSC);
      if (k > 3)
        chk(d & 16'h3300, {2'b00, grp_cfg, 2'b00, grp_cfg, 8'h00});
    end
    $display("test causes done");
  endtask
  task t_slow;
    @(posedge clk);
    mon_cfg <= 2'b00;
    osc_started <= 1'b0;
    wait_on(0);
    chk(16'(n < 4), 16'h0001);
    wr(OSC, 2'b10, {`CKSUP_KEY_HI1, 8'h00});
    wr(OSC, 2'b10, {`CKSUP_KEY_HI2, 8'h00});
    wr(OSC, 2'b10, 16'h0300);
    wr(OSC, 2'b01, {8'h00, `CKSUP_KEY_LO1});
    wr(OSC, 2'b01, {8'h00, `CKSUP_KEY_LO2});
    wr(OSC, 2'b01, 16'h0001);
    wr(OSC, 2'b01, {8'h00, `CKSUP_KEY_LO1});
    wr(OSC, 2'b01, {8'h00, `CKSUP_KEY_LO2});
    wr(OSC, 2'b01, 16'h0000);
    idle;
    osc_started <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OSC);
    chk(d & 16'h3309, 16'h1308);
    $display("test slow start and abort done");
  endtask
  task t_wdt;
    tick_en = 1'b1;
    wr(RST, 2'b01, 16'h0020);
    wr(CMD, 2'b01, 16'h0004);
    idle;
    wait_on(1);
    chk({15'h0, wake}, 16'h0001);
    chk({15'h0, isr_b}, 16'h0001);
    rd(RST);
    chk({15'h0, d[4]}, 16'h0000);
    wait_on(3);
    wait_on(2);
    rd(RST);
    chk({15'h0, d[4]}, 16'h0001);
    wr(RST, 2'b01, 16'h0000);
    idle;
    wdt_cfg <= 1'b1;
    wait_on(3);
    chk(16'(n < 4000), 16'h0001);
    wait_on(2);
    wdt_cfg <= 1'b0;
    tick_en = 1'b0;
    $display("test watchdog done");
  endtask
  initial begin
    {rst_b, reg_wr, reg_rd, por_event, bor_event, trap_lockup} = 6'h00;
    {illegal_op, wdt_cfg, clock_missing, tick_en} = 4'h0;
    {pin_b, osc_started, pll_locked, ref_rdy} = 4'hF;
    {reg_addr, reg_byte_en, mon_cfg, reg_wdata} = 22'h00_0000;
    grp_cfg = 2'h2;
    pud_sel = 2'h1;
    prim_cfg = 4'h3;
    {n_fail, num_checks, cyc} = 96'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_powerup;
    t_unlock;
    t_fail;
    t_causes;
    t_slow;
    t_wdt;
    end_sim;
  end
endmodule // cksup_tb_top
